// ### hdl/boot_mode_params.svh
`ifndef BOOT_MODE_PARAMS_SVH
`define BOOT_MODE_PARAMS_SVH

// serial clock and stream geometry
`define MODE_CLOCK_DIVIDE 256
`define DIVIDER_WIDTH 8
`define DIVIDER_RESET 8'h00
`define DIVIDER_STEP 8'h01
`define SAMPLE_PHASE 8'h7f
`define STREAM_BITS 256
`define BIT_COUNT_WIDTH 8
`define BIT_COUNT_RESET 8'h00
`define BIT_COUNT_STEP 8'h01
`define LAST_BIT_INDEX 8'hff
`define FIRST_HIGH_RESERVED_BIT 8'h13
`define WORD_WIDTH 32
`define WORD_LAST_BIT 5'h1f
`define FIFO_DEPTH 8

// mode word field positions
`define RSV_LOW_BIT 0
`define WB_PATTERN_MSB 4
`define WB_PATTERN_LSB 1
`define WB_PATTERN_LAST_CODE 4'h8
`define DIVISOR_MSB 7
`define DIVISOR_LSB 5
`define DIVISOR_BAD_CODE 3'h7
`define DIVISOR_BASE 4'h2
`define ENDIAN_BIT 8
`define PROTOCOL_MSB 10
`define PROTOCOL_LSB 9
`define TIMER_DISABLE_BIT 11
`define RSV_MID_BIT 12
`define STRENGTH_MSB 14
`define STRENGTH_LSB 13
`define TX_GATE_MSB 16
`define TX_GATE_LSB 15
`define RX_GATE_MSB 18
`define RX_GATE_LSB 17
`define RSV_HIGH_MSB 31
`define RSV_HIGH_LSB 19

// register map, byte addresses
`define ADDR_WIDTH 4
`define REG_CONTROL 4'h0
`define REG_STATUS 4'h4
`define REG_STREAM 4'h8
`define REG_MODE_WORD 4'hc
`define CONTROL_RELOAD_BIT 0

// reset values of held fields: decode of an all-zero stream
`define WORD_RESET 32'h0000_0000
`define PATTERN_RESET 4'h0
`define DIVISOR_RESET 4'h2
`define CLOCK_ENABLE_RESET 2'h3

`endif

// ### hdl/boot_mode_pkg.sv
`include "boot_mode_params.svh"
package boot_mode_pkg;

  typedef enum logic [1:0] {
    PHASE_IDLE = 2'b00,
    PHASE_LOAD = 2'b01,
    PHASE_DONE = 2'b10
  } load_phase_e;

  typedef enum logic [1:0] {
    PROTO_COMPAT = 2'b00,
    PROTO_RESERVED = 2'b01,
    PROTO_PIPELINED = 2'b10,
    PROTO_REISSUE = 2'b11
  } write_protocol_e;

  typedef enum logic [1:0] {
    DRIVE_67 = 2'b00,
    DRIVE_50 = 2'b01,
    DRIVE_100 = 2'b10,
    DRIVE_83 = 2'b11
  } drive_strength_e;

  typedef struct packed {
    load_phase_e phase;
    logic [`DIVIDER_WIDTH-1:0] divider;
    logic [`BIT_COUNT_WIDTH-1:0] bit_count;
    logic [`WORD_WIDTH-1:0] shifter;
    logic [`WORD_WIDTH-1:0] word;
    logic word_valid;
    logic [`WORD_WIDTH-1:0] mode_word;
    logic high_bits_set;
    logic [3:0] pattern;
    logic pattern_reserved;
    logic [3:0] divisor;
    logic divisor_reserved;
    logic big_endian;
    write_protocol_e protocol;
    logic timer_int_enable;
    drive_strength_e strength;
    logic [1:0] tx_enable;
    logic [1:0] rx_enable;
    logic reserved_error;
    logic [`WORD_WIDTH-1:0] read_data;
  } loader_state_s;

endpackage

// ### hdl/boot_mode_word_fifo.sv
`timescale 1ns/100ps
module boot_mode_word_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);

  localparam int PTR_W = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] slots;
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [PTR_W:0] count;
  } fifo_state_s;

  fifo_state_s state;
  fifo_state_s next_state;
  logic push;
  logic pop;

  assign in_ready_o = state.count != (PTR_W+1)'(DEPTH);
  assign out_valid_o = state.count != '0;
  assign out_data_o = state.slots[state.rd_ptr];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_comb
  begin
    next_state = state;
    if (push)
    begin
      next_state.slots[state.wr_ptr] = in_data_i;
      // explicit wrap keeps non power of two depths honest
      if (state.wr_ptr == PTR_W'(DEPTH - 1))
        next_state.wr_ptr = '0;
      else
        next_state.wr_ptr = state.wr_ptr + PTR_W'(1);
    end
    if (pop)
    begin
      if (state.rd_ptr == PTR_W'(DEPTH - 1))
        next_state.rd_ptr = '0;
      else
        next_state.rd_ptr = state.rd_ptr + PTR_W'(1);
    end
    if (push && !pop)
      next_state.count = state.count + (PTR_W+1)'(1);
    else if (pop && !push)
      next_state.count = state.count - (PTR_W+1)'(1);
  end

  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
      state <= '0;
    else
      state <= next_state;
  end

endmodule

// ### hdl/boot_mode_serial_loader.sv
// Implementation choices: the strobed register port and the address map.
`timescale 1ns/100ps
`include "boot_mode_params.svh"
module boot_mode_serial_loader (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic supply_good_i,
  input wire logic mode_data_i,
  output logic mode_clock_o,
  output logic load_done_o,
  output logic [3:0] writeback_pattern_o,
  output logic writeback_pattern_reserved_o,
  output logic [3:0] interface_clock_divisor_o,
  output logic divisor_reserved_o,
  output logic big_endian_o,
  output boot_mode_pkg::write_protocol_e write_protocol_o,
  output logic timer_interrupt_enable_o,
  output boot_mode_pkg::drive_strength_e drive_strength_o,
  output logic [1:0] transmit_clock_out_enable_o,
  output logic [1:0] receive_clock_out_enable_o,
  output logic reserved_bits_error_o,
  input wire logic [`ADDR_WIDTH-1:0] reg_address_i,
  input wire logic [`WORD_WIDTH-1:0] reg_write_data_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  output logic [`WORD_WIDTH-1:0] reg_read_data_o
);

  localparam boot_mode_pkg::loader_state_s STATE_RESET = '{
    phase: boot_mode_pkg::PHASE_IDLE,
    divider: `DIVIDER_RESET,
    bit_count: `BIT_COUNT_RESET,
    shifter: `WORD_RESET,
    word: `WORD_RESET,
    word_valid: 1'b0,
    mode_word: `WORD_RESET,
    high_bits_set: 1'b0,
    pattern: `PATTERN_RESET,
    pattern_reserved: 1'b0,
    divisor: `DIVISOR_RESET,
    divisor_reserved: 1'b0,
    big_endian: 1'b0,
    protocol: boot_mode_pkg::PROTO_COMPAT,
    timer_int_enable: 1'b1,
    strength: boot_mode_pkg::DRIVE_67,
    tx_enable: `CLOCK_ENABLE_RESET,
    rx_enable: `CLOCK_ENABLE_RESET,
    reserved_error: 1'b0,
    read_data: `WORD_RESET
  };

  boot_mode_pkg::loader_state_s state;
  boot_mode_pkg::loader_state_s next_state;

  logic loading;
  logic stall;
  logic sample_now;
  logic word_complete;
  logic last_bit;
  logic reload_request;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_pop;
  logic [`WORD_WIDTH-1:0] fifo_out_data;
  logic [`WORD_WIDTH-1:0] assembled;
  logic [`WORD_WIDTH-1:0] status_word;
  logic [`WORD_WIDTH-1:0] mode_bits;
  logic pattern_bad;
  logic divisor_bad;
  logic protocol_bad;
  logic low_reserved_set;

  assign loading = state.phase == boot_mode_pkg::PHASE_LOAD;

  // a pending word that the fifo cannot take freezes the serial clock,
  // so the stream waits instead of losing bits
  assign stall = loading && state.word_valid && !fifo_in_ready;

  // rising edge of the serial clock: divider steps from 7f to 80
  assign sample_now = loading && !stall && (state.divider == `SAMPLE_PHASE);

  // new bit enters at the top, so after 32 shifts bit 0 sits at the bottom
  assign assembled = {mode_data_i, state.shifter[`WORD_WIDTH-1:1]};

  assign word_complete = sample_now && (state.bit_count[4:0] == `WORD_LAST_BIT);
  assign last_bit = sample_now && (state.bit_count == `LAST_BIT_INDEX);

  assign reload_request = reg_write_i && (reg_address_i == `REG_CONTROL)
    && reg_write_data_i[`CONTROL_RELOAD_BIT];
  assign fifo_pop = reg_read_i && (reg_address_i == `REG_STREAM);

  // the first word holds every defined field
  assign mode_bits = state.mode_word;

  assign pattern_bad = mode_bits[`WB_PATTERN_MSB:`WB_PATTERN_LSB] > `WB_PATTERN_LAST_CODE;
  assign divisor_bad = mode_bits[`DIVISOR_MSB:`DIVISOR_LSB] == `DIVISOR_BAD_CODE;
  assign protocol_bad = boot_mode_pkg::write_protocol_e'(mode_bits[`PROTOCOL_MSB:`PROTOCOL_LSB])
    == boot_mode_pkg::PROTO_RESERVED;
  assign low_reserved_set = mode_bits[`RSV_LOW_BIT] || mode_bits[`RSV_MID_BIT];

  assign status_word = {
    12'h000,
    3'h0,
    fifo_out_valid,
    state.bit_count,
    3'h0,
    state.word_valid,
    state.reserved_error,
    stall,
    load_done_o,
    loading
  };

  always_comb
  begin
    next_state = state;
    next_state.read_data = `WORD_RESET;

    // free running outside a stall, also after the load ends
    if (!stall)
      next_state.divider = state.divider + `DIVIDER_STEP;

    if (state.word_valid && fifo_in_ready)
      next_state.word_valid = 1'b0;

    if (sample_now)
    begin
      next_state.shifter = assembled;
      next_state.bit_count = state.bit_count + `BIT_COUNT_STEP;
      if ((state.bit_count >= `FIRST_HIGH_RESERVED_BIT) && mode_data_i)
        next_state.high_bits_set = 1'b1;
    end

    // a new word may land in the cycle the old one leaves
    if (word_complete)
    begin
      next_state.word = assembled;
      next_state.word_valid = 1'b1;
      if (state.bit_count[`BIT_COUNT_WIDTH-1:5] == 3'h0)
        next_state.mode_word = assembled;
    end

    unique case (state.phase)
      boot_mode_pkg::PHASE_IDLE:
      begin
        if (supply_good_i)
        begin
          next_state.phase = boot_mode_pkg::PHASE_LOAD;
          next_state.bit_count = `BIT_COUNT_RESET;
          next_state.high_bits_set = 1'b0;
        end
      end
      boot_mode_pkg::PHASE_LOAD:
      begin
        if (last_bit)
        begin
          // fields change only here, never part way through a stream
          next_state.phase = boot_mode_pkg::PHASE_DONE;
          next_state.pattern = mode_bits[`WB_PATTERN_MSB:`WB_PATTERN_LSB];
          next_state.pattern_reserved = pattern_bad;
          next_state.divisor = {1'b0, mode_bits[`DIVISOR_MSB:`DIVISOR_LSB]} + `DIVISOR_BASE;
          next_state.divisor_reserved = divisor_bad;
          next_state.big_endian = mode_bits[`ENDIAN_BIT];
          next_state.protocol =
            boot_mode_pkg::write_protocol_e'(mode_bits[`PROTOCOL_MSB:`PROTOCOL_LSB]);
          next_state.timer_int_enable = !mode_bits[`TIMER_DISABLE_BIT];
          next_state.strength =
            boot_mode_pkg::drive_strength_e'(mode_bits[`STRENGTH_MSB:`STRENGTH_LSB]);
          next_state.tx_enable = ~mode_bits[`TX_GATE_MSB:`TX_GATE_LSB];
          next_state.rx_enable = ~mode_bits[`RX_GATE_MSB:`RX_GATE_LSB];
          // bit 255 is on the pin right now, so it joins the check directly
          next_state.reserved_error = low_reserved_set
            || (mode_bits[`RSV_HIGH_MSB:`RSV_HIGH_LSB] != 13'h0000)
            || state.high_bits_set
            || mode_data_i
            || pattern_bad
            || divisor_bad
            || protocol_bad;
        end
      end
      boot_mode_pkg::PHASE_DONE:
      begin
        // data input no longer looked at
        next_state.phase = boot_mode_pkg::PHASE_DONE;
      end
      default:
      begin
        next_state.phase = boot_mode_pkg::PHASE_IDLE;
      end
    endcase

    // loss of supply good aborts; held fields keep their values unless bit 255 is sampled in the same cycle
    if (!supply_good_i || reload_request)
      next_state.phase = boot_mode_pkg::PHASE_IDLE;

    if (reg_read_i)
    begin
      case (reg_address_i)
        `REG_STATUS:
          next_state.read_data = status_word;
        `REG_STREAM:
          next_state.read_data = fifo_out_valid ? fifo_out_data : `WORD_RESET;
        `REG_MODE_WORD:
          next_state.read_data = state.mode_word;
        default:
          next_state.read_data = `WORD_RESET;
      endcase
    end
  end

  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
      state <= STATE_RESET;
    else
      state <= next_state;
  end

  boot_mode_word_fifo #(
    .WIDTH(`WORD_WIDTH),
    .DEPTH(`FIFO_DEPTH)
  ) stream_fifo (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .in_valid_i(state.word_valid),
    .in_ready_o(fifo_in_ready),
    .in_data_i(state.word),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_pop),
    .out_data_o(fifo_out_data)
  );

  assign mode_clock_o = state.divider[`DIVIDER_WIDTH-1];
  assign load_done_o = state.phase == boot_mode_pkg::PHASE_DONE;
  assign writeback_pattern_o = state.pattern;
  assign writeback_pattern_reserved_o = state.pattern_reserved;
  assign interface_clock_divisor_o = state.divisor;
  assign divisor_reserved_o = state.divisor_reserved;
  assign big_endian_o = state.big_endian;
  assign write_protocol_o = state.protocol;
  assign timer_interrupt_enable_o = state.timer_int_enable;
  assign drive_strength_o = state.strength;
  assign transmit_clock_out_enable_o = state.tx_enable;
  assign receive_clock_out_enable_o = state.rx_enable;
  assign reserved_bits_error_o = state.reserved_error;
  assign reg_read_data_o = state.read_data;

endmodule

// ### testbench/boot_mode_serial_loader_monitor.sv
`timescale 1ns/100ps
module boot_mode_serial_loader_monitor (
  input logic clock_i,
  input logic reset_i,
  input logic supply_good_i,
  input logic mode_clock_o,
  input logic load_done_o,
  input logic [3:0] writeback_pattern_o,
  input logic writeback_pattern_reserved_o,
  input logic [3:0] interface_clock_divisor_o,
  input logic divisor_reserved_o,
  input logic big_endian_o,
  input boot_mode_pkg::write_protocol_e write_protocol_o,
  input boot_mode_pkg::drive_strength_e drive_strength_o,
  input logic reserved_bits_error_o,
  input logic reg_write_i,
  input logic reg_read_i,
  input logic [31:0] reg_read_data_o
);
  logic prev_clock;
  logic seen_toggle;
  logic [7:0] half_count;
  // the first half period after reset is not judged, its start is unknown
  always_ff @(posedge clock_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      prev_clock <= 1'h0;
      seen_toggle <= 1'h0;
      half_count <= 8'h00;
    end
    else
    begin
      prev_clock <= mode_clock_o;
      seen_toggle <= seen_toggle | (mode_clock_o != prev_clock);
      half_count <= (mode_clock_o != prev_clock) ? 8'h00 : half_count + 8'h01;
    end
  end
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (reset_i);
  a_half_period: assert property (mode_clock_o != prev_clock && seen_toggle |-> half_count == 8'h7f)
    else $error("serial clock half period is not 128 cycles");
  a_done_with_clock: assert property ($rose(load_done_o) |-> $rose(mode_clock_o))
    else $error("load done not aligned to a serial clock rise");
  a_supply_abort: assert property (!supply_good_i |=> !load_done_o)
    else $error("load done while supply good low");
  a_done_steady: assert property (load_done_o && supply_good_i && !reg_write_i |=> load_done_o)
    else $error("load done dropped without cause");
  a_clock_runs: assert property (load_done_o |-> ##[1:128] $changed(mode_clock_o))
    else $error("serial clock stopped after load");
  a_fields_hold: assert property (!$rose(load_done_o) |-> $stable({writeback_pattern_o,
    interface_clock_divisor_o, big_endian_o, write_protocol_o, drive_strength_o}))
    else $error("mode fields changed outside load completion");
  a_pattern_code: assert property (writeback_pattern_reserved_o == (writeback_pattern_o > 4'h8))
    else $error("pattern reserved flag wrong");
  a_error_flag: assert property (writeback_pattern_reserved_o || divisor_reserved_o ||
    write_protocol_o == boot_mode_pkg::PROTO_RESERVED |-> reserved_bits_error_o)
    else $error("reserved code without error flag");
  a_read_idle: assert property (!$past(reg_read_i) |-> reg_read_data_o == 32'h0000_0000)
    else $error("read data outside read answer cycle");
  c_done: cover property ($rose(load_done_o));
  c_abort: cover property ($fell(supply_good_i));
  c_read: cover property (reg_read_i ##1 reg_read_data_o != 32'h0000_0000);
endmodule

bind boot_mode_serial_loader boot_mode_serial_loader_monitor u_monitor (.clock_i(clock_i), .reset_i(reset_i),
  .supply_good_i(supply_good_i), .mode_clock_o(mode_clock_o), .load_done_o(load_done_o),
  .writeback_pattern_o(writeback_pattern_o), .writeback_pattern_reserved_o(writeback_pattern_reserved_o),
  .interface_clock_divisor_o(interface_clock_divisor_o), .divisor_reserved_o(divisor_reserved_o),
  .big_endian_o(big_endian_o), .write_protocol_o(write_protocol_o), .drive_strength_o(drive_strength_o),
  .reserved_bits_error_o(reserved_bits_error_o), .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
  .reg_read_data_o(reg_read_data_o));

// ### testbench/boot_mode_source.sv
`timescale 1ns/100ps
module boot_mode_source (
  input wire logic clock_i,
  input wire logic supply_good_i,
  input wire logic mode_clock_i,
  input wire logic [31:0] stream_i,
  output logic mode_data_o
);
  logic [8:0] index = 9'h000;
  logic sampled = 1'h0;
  logic prev_clock = 1'h0;
  logic filler = 1'h0;
  // advance only after a falling edge that follows a sample
  always @(posedge clock_i)
  begin
    prev_clock <= mode_clock_i;
    filler <= ~filler;
    if (!supply_good_i)
      index <= 9'h000;
    else if (mode_clock_i && !prev_clock)
      sampled <= 1'h1;
    else if (!mode_clock_i && prev_clock && sampled)
    begin
      index <= index + 9'h001;
      sampled <= 1'h0;
    end
    if (!supply_good_i)
      sampled <= 1'h0;
  end
  // past bit 255 the line wiggles so a design that still samples is caught
  assign mode_data_o = index[8] ? filler : (index < 9'h020 && index != 9'h000 && index != 9'h00c) ?
    stream_i[index[4:0]] : 1'h0;
endmodule

// ### testbench/boot_mode_serial_loader_tb.sv
`timescale 1ns/100ps
`include "boot_mode_params.svh"
module boot_mode_serial_loader_tb;
  logic clock_i = 1'h0;
  logic reset_i = 1'h1;
  logic supply_good_i = 1'h0;
  logic mode_data_i;
  logic mode_clock_o;
  logic load_done_o;
  logic [3:0] writeback_pattern_o;
  logic writeback_pattern_reserved_o;
  logic [3:0] interface_clock_divisor_o;
  logic divisor_reserved_o;
  logic big_endian_o;
  boot_mode_pkg::write_protocol_e write_protocol_o;
  logic timer_interrupt_enable_o;
  boot_mode_pkg::drive_strength_e drive_strength_o;
  logic [1:0] transmit_clock_out_enable_o;
  logic [1:0] receive_clock_out_enable_o;
  logic reserved_bits_error_o;
  logic [3:0] reg_address_i = 4'h0;
  logic [31:0] reg_write_data_i = 32'h0000_0000;
  logic reg_write_i = 1'h0;
  logic reg_read_i = 1'h0;
  logic [31:0] reg_read_data_o;
  logic [31:0] stream = 32'h0007_effe;
  logic [31:0] data;
  logic [20:0] fields;
  logic last;
  int bad_count = 0;
  int checks = 0;
  int rises;
  always #10 clock_i = ~clock_i;
  assign fields = {writeback_pattern_o, writeback_pattern_reserved_o, interface_clock_divisor_o, divisor_reserved_o,
    big_endian_o, write_protocol_o, timer_interrupt_enable_o, drive_strength_o, transmit_clock_out_enable_o,
    receive_clock_out_enable_o, reserved_bits_error_o};
  boot_mode_serial_loader u_dut (.clock_i(clock_i), .reset_i(reset_i), .supply_good_i(supply_good_i),
    .mode_data_i(mode_data_i), .mode_clock_o(mode_clock_o), .load_done_o(load_done_o),
    .writeback_pattern_o(writeback_pattern_o), .writeback_pattern_reserved_o(writeback_pattern_reserved_o),
    .interface_clock_divisor_o(interface_clock_divisor_o), .divisor_reserved_o(divisor_reserved_o),
    .big_endian_o(big_endian_o), .write_protocol_o(write_protocol_o),
    .timer_interrupt_enable_o(timer_interrupt_enable_o), .drive_strength_o(drive_strength_o),
    .transmit_clock_out_enable_o(transmit_clock_out_enable_o), .receive_clock_out_enable_o(receive_clock_out_enable_o),
    .reserved_bits_error_o(reserved_bits_error_o), .reg_address_i(reg_address_i), .reg_write_data_i(reg_write_data_i),
    .reg_write_i(reg_write_i), .reg_read_i(reg_read_i), .reg_read_data_o(reg_read_data_o));
  boot_mode_source u_source (.clock_i(clock_i), .supply_good_i(supply_good_i), .mode_clock_i(mode_clock_o),
    .stream_i(stream), .mode_data_o(mode_data_i));
  function automatic logic [20:0] exp_fields(input logic [31:0] w);
    logic pr;
    logic dr;
    pr = w[4:1] > 4'h8;
    dr = w[7:5] == 3'h7;
    return {w[4:1], pr, {1'h0, w[7:5]} + 4'h2, dr, w[8], w[10:9], ~w[11], w[14:13], ~w[16:15], ~w[18:17],
      pr | dr | (w[10:9] == 2'h1)};
  endfunction
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] want);
    checks++;
    if (got !== want)
    begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, want);
    end
  endtask
  task automatic tick;
    @(posedge clock_i);
    #1;
  endtask
  task automatic wait_fall;
    int n;
    n = 0;
    while (mode_clock_o !== 1'h1 && n < 600)
    begin
      tick();
      n++;
    end
    while (mode_clock_o !== 1'h0 && n < 600)
    begin
      tick();
      n++;
    end
    if (n >= 600)
    begin
      bad_count++;
      conclude();
    end
  endtask
  task automatic reg_read(input logic [3:0] a);
    @(posedge clock_i);
    reg_address_i <= a;
    reg_read_i <= 1'h1;
    @(posedge clock_i);
    reg_read_i <= 1'h0;
    #1 data = reg_read_data_o;
  endtask
  initial
  begin
    void'($urandom(36));
    repeat (8) @(posedge clock_i);
    reset_i <= 1'h0;
    tick();
    check({11'h000, fields}, {11'h000, exp_fields(32'h0000_0000)});
    // aborted load with every field bit set must leave the fields alone
    wait_fall();
    @(posedge clock_i);
    supply_good_i <= 1'h1;
    repeat (800) @(posedge clock_i);
    supply_good_i <= 1'h0;
    repeat (4) tick();
    check({11'h000, fields}, {11'h000, exp_fields(32'h0000_0000)});
    check({31'h0000_0000, load_done_o}, 32'h0000_0000);
    stream = $urandom & 32'h0007_effe;
    wait_fall();
    @(posedge clock_i);
    supply_good_i <= 1'h1;
    rises = 0;
    last = 1'h0;
    for (int n = 0; n < 70000 && load_done_o !== 1'h1; n++)
    begin
      tick();
      if (mode_clock_o === 1'h1 && last === 1'h0)
        rises++;
      last = mode_clock_o;
    end
    if (load_done_o !== 1'h1)
    begin
      bad_count++;
      conclude();
    end
    check(rises, 32'h0000_0100);
    check({11'h000, fields}, {11'h000, exp_fields(stream)});
    repeat (600) tick();
    check({11'h000, fields}, {11'h000, exp_fields(stream)});
    check({31'h0000_0000, load_done_o}, 32'h0000_0001);
    reg_read(`REG_MODE_WORD);
    check(data, stream);
    reg_read(`REG_STATUS);
    check(data & 32'h0001_0002, 32'h0001_0002);
    for (int i = 0; i < 9; i++)
    begin
      reg_read(`REG_STREAM);
      check(data, (i == 0) ? stream : 32'h0000_0000);
    end
    reg_read(`REG_STATUS);
    check(data & 32'h0001_0000, 32'h0000_0000);
    reg_read(4'h2);
    check(data, 32'h0000_0000);
    @(posedge clock_i);
    reg_address_i <= `REG_CONTROL;
    reg_write_data_i <= 32'h0000_0001;
    reg_write_i <= 1'h1;
    @(posedge clock_i);
    reg_write_i <= 1'h0;
    tick();
    check({31'h0000_0000, load_done_o}, 32'h0000_0000);
    // reset in mid-run must drop the held fields back to the all-zero decode
    @(posedge clock_i);
    reset_i <= 1'h1;
    repeat (2) @(posedge clock_i);
    reset_i <= 1'h0;
    tick();
    check({11'h000, fields}, {11'h000, exp_fields(32'h0000_0000)});
    check({31'h0000_0000, load_done_o}, 32'h0000_0000);
    conclude();
  end
endmodule
